// file: src/ddblc_top.sv
`timescale 1ns/100ps
`include "ddblc_consts.svh"
module ddblc_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic data_wr_en,
  input wire logic [2:0] data_wr_ch,
  input wire logic [11:0] data_wr_val,
  input wire logic [2:0] data_rd_ch,
  output logic [11:0] data_rd_val,
  input wire logic load_wr_en,
  input wire logic [15:0] load_wr_val,
  input wire logic ext_load_pin,
  input wire logic cfg_wr_en,
  input wire logic [7:0] sync_load_select_in,
  input wire logic [7:0] output_gain_select_in,
  input wire logic ref_wr_en,
  input wire logic ref_source_select_in,
  input wire logic ref_level_select_in,
  input wire logic [7:0] channel_power_on,
  output logic [7:0] sync_load_select,
  output logic [7:0] output_gain_select,
  output logic ref_source_select,
  output logic ref_level_select,
  output logic int_load_pulse,
  output logic [95:0] chan_out_code
);
  typedef struct packed {
    ddblc_pkg::ddblc_code_t [7:0] input_reg;
    ddblc_pkg::ddblc_code_t [7:0] latch;
    ddblc_pkg::ddblc_code_t [7:0] out_code;
    ddblc_pkg::ddblc_code_t rd_val;
    logic [7:0] sls;
    logic [7:0] gain;
    logic ref_src;
    logic ref_lvl;
    logic int_pulse;
    logic pin_prev;
  } ddblc_state_t;

  ddblc_state_t st_reg;
  ddblc_state_t st_next;
  logic pin_sync;
  logic pin_rise;
  logic load_event;
  logic trig_word;

  ddblc_sync u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(ext_load_pin),
    .sync_out(pin_sync)
  );

  assign pin_rise = pin_sync & ~st_reg.pin_prev;
  assign trig_word = load_wr_en &&
    (load_wr_val == `DDBLC_LOAD_TRIGGER);
  assign load_event = pin_rise | trig_word;

  always_comb begin
    st_next = st_reg;
    st_next.pin_prev = pin_sync;
    st_next.int_pulse = trig_word;
    if (cfg_wr_en) begin
      st_next.sls = sync_load_select_in;
      st_next.gain = output_gain_select_in;
    end
    if (ref_wr_en) begin
      st_next.ref_src = ref_source_select_in;
      st_next.ref_lvl = ref_level_select_in;
    end
    for (int i = 0; i < `DDBLC_NUM_CH; i++) begin
      // event copies every selected channel at once
      if (load_event && st_reg.sls[i]) begin
        st_next.latch[i] = st_reg.input_reg[i];
      end
      if (data_wr_en && data_wr_ch == i[2:0]) begin
        st_next.input_reg[i] = data_wr_val;
        if (!st_reg.sls[i]) begin
          st_next.latch[i] = data_wr_val;
        end
      end
      // output follows latch only while powered
      if (channel_power_on[i]) begin
        st_next.out_code[i] = st_reg.latch[i];
      end
    end
    st_next.rd_val = st_reg.latch[data_rd_ch];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign data_rd_val = st_reg.rd_val;
  assign sync_load_select = st_reg.sls;
  assign output_gain_select = st_reg.gain;
  assign ref_source_select = st_reg.ref_src;
  assign ref_level_select = st_reg.ref_lvl;
  assign int_load_pulse = st_reg.int_pulse;
  assign chan_out_code = st_reg.out_code;

  property p_trig;
    @(posedge clk) disable iff (!rst_n)
    trig_word |=> int_load_pulse;
  endproperty
  a_trig: assert property (p_trig) else $error("no load pulse");

  property p_bad_word;
    @(posedge clk) disable iff (!rst_n)
    (load_wr_en && load_wr_val != `DDBLC_LOAD_TRIGGER && !pin_rise
      && !data_wr_en) |=> (st_reg.latch == $past(st_reg.latch));
  endproperty
  a_bad_word: assert property (p_bad_word)
    else $error("bad word load");

  property p_async;
    @(posedge clk) disable iff (!rst_n)
    (data_wr_en && !st_reg.sls[data_wr_ch])
      |=> st_reg.latch[$past(data_wr_ch)] == $past(data_wr_val);
  endproperty
  a_async: assert property (p_async)
    else $error("latch not written");

  property p_sync_hold;
    @(posedge clk) disable iff (!rst_n)
    (data_wr_en && st_reg.sls[data_wr_ch] && !load_event)
      |=> st_reg.latch[$past(data_wr_ch)] ==
          $past(st_reg.latch[data_wr_ch]);
  endproperty
  a_sync_hold: assert property (p_sync_hold)
    else $error("latch moved");

  property p_event;
    @(posedge clk) disable iff (!rst_n)
    (load_event && st_reg.sls[0] && !(data_wr_en && data_wr_ch == 3'h0))
      |=> st_reg.latch[0] == $past(st_reg.input_reg[0]);
  endproperty
  a_event: assert property (p_event) else $error("load missed");

  sequence s_pin_rise;
    !pin_sync ##1 pin_sync;
  endsequence
  property p_pin;
    @(posedge clk) disable iff (!rst_n)
    s_pin_rise |-> load_event;
  endproperty
  a_pin: assert property (p_pin) else $error("edge not seen");

  property p_read;
    @(posedge clk) disable iff (!rst_n)
    1'b1 |=> data_rd_val == $past(st_reg.latch[data_rd_ch]);
  endproperty
  a_read: assert property (p_read) else $error("read wrong");

  property p_pdn;
    @(posedge clk) disable iff (!rst_n)
    !channel_power_on[0] |=> $stable(chan_out_code[11:0]);
  endproperty
  a_pdn: assert property (p_pdn) else $error("output moved");

  property p_rst;
    @(posedge clk) !rst_n |=> (st_reg.latch == '0 && !ref_source_select);
  endproperty
  a_rst: assert property (p_rst) else $error("reset not clear");

  property p_no_pulse;
    @(posedge clk) disable iff (!rst_n)
    !trig_word |=> !int_load_pulse;
  endproperty
  a_no_pulse: assert property (p_no_pulse)
    else $error("stray pulse");

  property p_gain_wr;
    @(posedge clk) disable iff (!rst_n)
    cfg_wr_en |=> output_gain_select == $past(output_gain_select_in);
  endproperty
  a_gain_wr: assert property (p_gain_wr)
    else $error("gain not stored");

  property p_gain_hold;
    @(posedge clk) disable iff (!rst_n)
    !cfg_wr_en |=> $stable(output_gain_select);
  endproperty
  a_gain_hold: assert property (p_gain_hold)
    else $error("gain moved");

  property p_unsel;
    @(posedge clk) disable iff (!rst_n)
    (load_event && !st_reg.sls[1] && !(data_wr_en && data_wr_ch == 3'h1))
      |=> $stable(st_reg.latch[1]);
  endproperty
  a_unsel: assert property (p_unsel)
    else $error("unselected latch moved");

  // raw pin edge reaches the event after the two sync stages
  sequence s_raw_rise;
    !ext_load_pin ##1 ext_load_pin;
  endsequence
  property p_pin_delay;
    @(posedge clk) disable iff (!rst_n)
    s_raw_rise |-> ##2 load_event;
  endproperty
  a_pin_delay: assert property (p_pin_delay)
    else $error("edge latency wrong");

  sequence s_direct_wr;
    data_wr_en && data_wr_ch == 3'h0 && !st_reg.sls[0];
  endsequence
  property p_direct_out;
    @(posedge clk) disable iff (!rst_n)
    s_direct_wr ##1 channel_power_on[0]
      |=> chan_out_code[11:0] == $past(data_wr_val, 2);
  endproperty
  a_direct_out: assert property (p_direct_out)
    else $error("output not updated");

  for (genvar c = 0; c < `DDBLC_NUM_CH; c++) begin : g_follow
    property p_follow;
      @(posedge clk) disable iff (!rst_n)
      channel_power_on[c] |=> chan_out_code[`DDBLC_DATA_W*c +: `DDBLC_DATA_W]
        == $past(st_reg.latch[c]);
    endproperty
    a_follow: assert property (p_follow)
      else $error("output not latch");
  end
endmodule

// file: src/ddblc_consts.svh
`ifndef DDBLC_CONSTS_SVH
`define DDBLC_CONSTS_SVH
`define DDBLC_NUM_CH 8
`define DDBLC_CH_AW 3
`define DDBLC_DATA_W 12
`define DDBLC_LOAD_W 16
`define DDBLC_LOAD_TRIGGER 16'hbb00
`define DDBLC_DATA_RST 12'h000
`define DDBLC_CFG_RST 8'h00
`define DDBLC_REF_RST 1'b0
`endif

// file: src/ddblc_pkg.sv
package ddblc_pkg;
  typedef logic [11:0] ddblc_code_t;
  typedef logic [2:0] ddblc_chan_t;
endpackage

// file: src/ddblc_sync.sv
`timescale 1ns/100ps
`include "ddblc_consts.svh"
module ddblc_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic sync_out
);
  typedef struct packed {
    logic meta;
    logic stable;
  } ddblc_sync_state_t;
  ddblc_sync_state_t st_reg;
  ddblc_sync_state_t st_next;
  always_comb begin
    st_next = st_reg;
    st_next.meta = async_in;
    st_next.stable = st_reg.meta;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign sync_out = st_reg.stable;
endmodule

// file: testbench/ddblc_host.sv
`timescale 1ns/100ps
module ddblc_host (
  input wire logic clk,
  output logic data_wr_en = 1'h0,
  output logic [2:0] data_wr_ch = 3'h0,
  output logic [11:0] data_wr_val = 12'h000,
  output logic load_wr_en = 1'h0,
  output logic [15:0] load_wr_val = 16'h0000,
  output logic ext_load_pin = 1'h0,
  output logic cfg_wr_en = 1'h0,
  output logic [7:0] sync_load_select_in = 8'h00,
  output logic [7:0] output_gain_select_in = 8'h00
);
  task automatic wr(input logic [2:0] c, input logic [11:0] v);
    @(posedge clk);
    data_wr_ch <= c;
    data_wr_val <= v;
    data_wr_en <= 1'h1;
    @(posedge clk);
    data_wr_en <= 1'h0;
  endtask
  task automatic ld(input logic [15:0] w);
    @(posedge clk);
    load_wr_val <= w;
    load_wr_en <= 1'h1;
    @(posedge clk);
    load_wr_en <= 1'h0;
  endtask
  task automatic cfg(input logic [7:0] s, input logic [7:0] g);
    @(posedge clk);
    sync_load_select_in <= s;
    output_gain_select_in <= g;
    cfg_wr_en <= 1'h1;
    @(posedge clk);
    cfg_wr_en <= 1'h0;
  endtask
  // raised only after selects and data are in place
  task automatic pin();
    @(posedge clk);
    ext_load_pin <= 1'h1;
    repeat (8) @(posedge clk);
    ext_load_pin <= 1'h0;
  endtask
endmodule

// file: testbench/ddblc_top_bench.sv
`timescale 1ns/100ps
module ddblc_top_bench;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic ref_wr_en = 1'h0;
  logic ref_source_select_in = 1'h1;
  logic ref_level_select_in = 1'h1;
  logic [2:0] data_rd_ch = 3'h0;
  logic [7:0] channel_power_on = 8'hff;
  logic [7:0] sel = 8'h00;
  logic data_wr_en, load_wr_en, ext_load_pin, cfg_wr_en, int_load_pulse;
  logic ref_source_select, ref_level_select;
  logic [2:0] data_wr_ch;
  logic [11:0] data_wr_val, data_rd_val;
  logic [15:0] load_wr_val;
  logic [7:0] sync_load_select_in, output_gain_select_in, sync_load_select;
  logic [7:0] output_gain_select;
  logic [95:0] chan_out_code;
  int n_mismatch, n_compared, g, inreg[8], lat[8], outv[8];
  ddblc_top u_ddblc_top (
    .clk(clk),
    .rst_n(rst_n),
    .data_wr_en(data_wr_en),
    .data_wr_ch(data_wr_ch),
    .data_wr_val(data_wr_val),
    .data_rd_ch(data_rd_ch),
    .data_rd_val(data_rd_val),
    .load_wr_en(load_wr_en),
    .load_wr_val(load_wr_val),
    .ext_load_pin(ext_load_pin),
    .cfg_wr_en(cfg_wr_en),
    .sync_load_select_in(sync_load_select_in),
    .output_gain_select_in(output_gain_select_in),
    .ref_wr_en(ref_wr_en),
    .ref_source_select_in(ref_source_select_in),
    .ref_level_select_in(ref_level_select_in),
    .channel_power_on(channel_power_on),
    .sync_load_select(sync_load_select),
    .output_gain_select(output_gain_select),
    .ref_source_select(ref_source_select),
    .ref_level_select(ref_level_select),
    .int_load_pulse(int_load_pulse),
    .chan_out_code(chan_out_code)
  );
  ddblc_host u_ddblc_host (
    .clk(clk),
    .data_wr_en(data_wr_en),
    .data_wr_ch(data_wr_ch),
    .data_wr_val(data_wr_val),
    .load_wr_en(load_wr_en),
    .load_wr_val(load_wr_val),
    .ext_load_pin(ext_load_pin),
    .cfg_wr_en(cfg_wr_en),
    .sync_load_select_in(sync_load_select_in),
    .output_gain_select_in(output_gain_select_in)
  );
  initial forever #2 clk = ~clk;
  task automatic final_report();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic sweep();
    repeat (6) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      if (channel_power_on[i]) outv[i] = lat[i];
      @(posedge clk);
      data_rd_ch <= 3'(i);
      repeat (2) @(negedge clk);
      chk(data_rd_val, lat[i]);
      chk(chan_out_code[12*i+:12], outv[i]);
    end
  endtask
  task automatic wr_all(input logic [7:0] s);
    sel = s;
    u_ddblc_host.cfg(sel, g[7:0]);
    for (int c = 0; c < 8; c++) begin
      inreg[c] = $urandom % 4096;
      u_ddblc_host.wr(3'(c), 12'(inreg[c]));
      if (!sel[c]) lat[c] = inreg[c];
    end
  endtask
  task automatic load();
    for (int i = 0; i < 8; i++)
      if (sel[i]) lat[i] = inreg[i];
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    void'($urandom(34));
    sweep();
    chk({ref_source_select, ref_level_select}, 2'h0);
    g = $urandom;
    wr_all(8'h00);
    chk(output_gain_select, g[7:0]);
    sweep();
    wr_all(8'h0f);
    chk(sync_load_select, 8'h0f);
    sweep();
    u_ddblc_host.ld(16'hbb01);
    @(negedge clk);
    chk(int_load_pulse, 1'h0);
    sweep();
    u_ddblc_host.ld(16'hbb00);
    @(negedge clk);
    chk(int_load_pulse, 1'h1);
    load();
    sweep();
    // ch0 off before its direct write, ch7 off across the pin load
    @(posedge clk);
    channel_power_on <= 8'h7e;
    wr_all(8'hf0);
    u_ddblc_host.pin();
    load();
    sweep();
    @(posedge clk);
    channel_power_on <= 8'hff;
    sweep();
    @(posedge clk);
    ref_wr_en <= 1'h1;
    @(posedge clk);
    ref_wr_en <= 1'h0;
    @(negedge clk);
    chk({ref_source_select, ref_level_select}, 2'h3);
    // second reset in mid-run
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    foreach (lat[i]) begin
      lat[i] = 0;
      inreg[i] = 0;
    end
    sweep();
    chk({ref_source_select, ref_level_select}, 2'h0);
    chk({sync_load_select, output_gain_select}, 16'h0000);
    // loading every channel exposes any input register left uncleared
    u_ddblc_host.cfg(8'hff, 8'h00);
    sel = 8'hff;
    u_ddblc_host.ld(16'hbb00);
    load();
    sweep();
    final_report();
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    final_report();
  end
endmodule
